// ===== hdl/fcia_top.sv
/*
  fabric register indirect access engine: command and value registers on an
  ahb-lite slave, launching single accesses into the fabric register space.
  assumes one ahb master, word-only transfers, and a fabric that acks each
  request once, writing only the enabled byte lanes.
*/
// What this block does
// - writing busy one launches the selected access
// - busy stays set until the access completes
// - read data captured on the edge busy clears
// - direction bit: zero writes, one reads
// - step up: value write launches, then increments
// - step up: value read increments and launches
// - step down: value write launches, then decrements
// - step down: value read decrements and launches
// - increment wins when both steps enabled
// - lane enables qualify fabric writes
// - lane bit n covers byte n
// - low sixteen bits hold fabric index
// - value register carries 32-bit data
// - value read depends on direction bit
`timescale 1ns/100ps
`default_nettype none

module fcia_top (
  input  wire logic                    hclk,       // system clock
  input  wire logic                    hresetn,    // async reset, active low
  input  wire logic                    hsel,       // slave select
  input  wire logic [11:0]             haddr,      // byte address
  input  wire logic [1:0]              htrans,     // transfer type
  input  wire logic                    hwrite,     // write when high
  input  wire logic [2:0]              hsize,      // transfer size
  input  wire logic [31:0]             hwdata,     // write data
  input  wire logic                    hready,     // bus ready in
  output logic      [31:0]             hrdata,     // read data
  output logic                         hreadyout,  // slave ready
  output logic                         hresp,      // always okay
  output fcia_pkg::fcia_fab_req_t      fab_req,    // fabric request
  input  wire fcia_pkg::fcia_fab_rsp_t fab_rsp     // fabric answer
);

  // register state
  fcia_pkg::fcia_cmd_t cmd_r;        // command register
  fcia_pkg::fcia_cmd_t cmd_nxt;      // its next value
  logic [31:0]         wval_r;       // last host-written value
  logic [31:0]         rval_r;       // last fabric read value
  logic [31:0]         rval_nxt;     // fabric value as it stands after this edge
  logic [31:0]         hrdata_r;     // registered read data
  logic [31:0]         hrdata_nxt;   // next read data

  // address phase capture
  logic        dp_wr_r;              // data phase is a write
  logic        dp_rd_r;              // data phase is a read
  logic [11:0] dp_addr_r;            // data phase address

  // sequencer handshake
  logic seq_done;                    // access finished
  logic seq_busy;                    // access in flight
  logic launch;                      // start an access

  // step a 16-bit index by one, wrapping; used for both directions
  function automatic logic [15:0] step_index(input logic [15:0] idx, input logic up);
    step_index = up ? 16'(idx + 16'h0001) : 16'(idx - 16'h0001);
  endfunction

  // ahb address decode
  wire addr_valid = hsel && hready &&
                    (htrans == fcia_pkg::FCIA_HTRANS_NONSEQ ||
                     htrans == fcia_pkg::FCIA_HTRANS_SEQ);
  wire rd_phase   = addr_valid && !hwrite;

  // data phase decode
  wire wr_cmd   = dp_wr_r && (dp_addr_r == fcia_pkg::FCIA_CMD_OFS);
  wire wr_value = dp_wr_r && (dp_addr_r == fcia_pkg::FCIA_VALUE_OFS);
  wire rd_value = dp_rd_r && (dp_addr_r == fcia_pkg::FCIA_VALUE_OFS);

  // stepping selection: increment has precedence over decrement
  wire stepping = cmd_r.step_up || cmd_r.step_dn;
  wire step_up  = cmd_r.step_up;

  // a data read launches on the same data phase it is returned in
  wire auto_rd = rd_value && stepping;
  wire auto_wr = wr_value && stepping;

  // bits of the command the host may write; the pending bit only sets
  wire host_go = wr_cmd && hwdata[fcia_pkg::FCIA_PEND_BIT];

  // index used for the launched access: a stepped read moves first
  wire [15:0] launch_index = auto_rd ? step_index(cmd_r.index, step_up) :
                                       cmd_r.index;

  // launch only from idle; a request while busy is dropped
  assign launch = !seq_busy && !cmd_r.pending && (host_go || auto_wr || auto_rd);

  // read data landing on this edge is already visible to a read issued now,
  // so a host that sees busy drop never reads the stale value
  assign rval_nxt = (seq_done && fab_req.rd) ? fab_rsp.rdata : rval_r;

  // next command register value
  always_comb begin
    cmd_nxt = cmd_r;
    if (wr_cmd && !cmd_r.pending) begin
      // plain host update of the control fields
      cmd_nxt.dir_read = hwdata[fcia_pkg::FCIA_DIR_BIT];
      cmd_nxt.step_up  = hwdata[fcia_pkg::FCIA_UP_BIT];
      cmd_nxt.step_dn  = hwdata[fcia_pkg::FCIA_DOWN_BIT];
      cmd_nxt.lanes    = hwdata[fcia_pkg::FCIA_LANE_HI:fcia_pkg::FCIA_LANE_LO];
      cmd_nxt.index    = hwdata[fcia_pkg::FCIA_INDEX_HI:0];
    end
    if (auto_rd && launch) begin
      // pre-step the index, touching nothing else
      cmd_nxt.index = launch_index;
    end
    if (launch) begin
      cmd_nxt.pending = 1'b1;
    end
    if (seq_done) begin
      cmd_nxt.pending = 1'b0;
      if (!fab_req.rd && stepping) begin
        // write finished: post-step the index
        cmd_nxt.index = step_index(cmd_r.index, step_up);
      end
    end
  end

  // command register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_r <= '{pending: 1'b0, dir_read: 1'b0, step_up: 1'b0, step_dn: 1'b0,
                 lanes: fcia_pkg::FCIA_LANE_RST, index: fcia_pkg::FCIA_INDEX_RST};
    end else begin
      cmd_r <= cmd_nxt;
    end
  end

  // host-written value; ignored while an access is pending
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wval_r <= fcia_pkg::FCIA_VALUE_RST;
    end else if (wr_value && !cmd_r.pending) begin
      wval_r <= hwdata;
    end
  end

  // fabric read data lands in the same edge the pending bit drops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rval_r <= fcia_pkg::FCIA_VALUE_RST;
    end else if (seq_done && fab_req.rd) begin
      rval_r <= fab_rsp.rdata;
    end
  end

  // address phase capture; the slave never inserts wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_r   <= 1'b0;
      dp_rd_r   <= 1'b0;
      dp_addr_r <= 12'h000;
    end else begin
      dp_wr_r   <= addr_valid && hwrite;
      dp_rd_r   <= rd_phase;
      dp_addr_r <= haddr;
    end
  end

  // read mux, sampled in the address phase so data stands in the data phase
  always_comb begin
    hrdata_nxt = 32'h0000_0000;
    if (rd_phase && haddr == fcia_pkg::FCIA_CMD_OFS) begin
      // reserved bits 27:20 read as zero
      hrdata_nxt = {cmd_nxt.pending, cmd_nxt.dir_read, cmd_nxt.step_up,
                    cmd_nxt.step_dn, 8'h00, cmd_nxt.lanes, cmd_nxt.index};
    end else if (rd_phase && haddr == fcia_pkg::FCIA_VALUE_OFS) begin
      hrdata_nxt = cmd_nxt.dir_read ? rval_nxt : wval_r;
    end
  end

  // read data register; unmapped reads return zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else begin
      hrdata_r <= hrdata_nxt;
    end
  end

  assign hrdata    = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // access sequencer; write data comes straight from the data phase when auto.
  // fields come from the next command value, so a command write that sets
  // busy launches with the direction, lanes and index carried in that write
  fcia_seq u_seq (
    .hclk    (hclk),
    .hresetn (hresetn),
    .launch  (launch),
    .rd      (auto_wr ? 1'b0 : (auto_rd ? 1'b1 : cmd_nxt.dir_read)),
    .addr    (cmd_nxt.index),
    .lanes   (cmd_nxt.lanes),
    .wdata   (auto_wr ? hwdata : wval_r),
    .fab_req (fab_req),
    .fab_rsp (fab_rsp),
    .done    (seq_done),
    .busy    (seq_busy)
  );

endmodule

`default_nettype wire

// ===== hdl/fcia_pkg.sv
/*
  package for the fabric register indirect access engine: register offsets,
  command field positions, reset values, state codes and carrier structs.
  assumes a 32-bit ahb-lite register bus and a 16-bit fabric address space.
*/
package fcia_pkg;

  // register byte offsets
  localparam logic [11:0] FCIA_VALUE_OFS   = 12'h1ac;  // fabric_access_value
  localparam logic [11:0] FCIA_CMD_OFS     = 12'h1b0;  // fabric_access_command

  // command field positions
  localparam int FCIA_PEND_BIT    = 31;  // indirect_op_pending
  localparam int FCIA_DIR_BIT     = 30;  // access_direction_sel
  localparam int FCIA_UP_BIT      = 29;  // auto increment enable
  localparam int FCIA_DOWN_BIT    = 28;  // addr_step_down_en
  localparam int FCIA_LANE_LO     = 16;  // lane_enables low bit
  localparam int FCIA_LANE_HI     = 19;  // lane_enables high bit
  localparam int FCIA_INDEX_HI    = 15;  // fabric_reg_index high bit

  // reset values
  localparam logic [31:0] FCIA_VALUE_RST = 32'h0000_0000;
  localparam logic [15:0] FCIA_INDEX_RST = 16'h0000;
  localparam logic [3:0]  FCIA_LANE_RST  = 4'h0;

  // ahb encodings used by the slave
  localparam logic [1:0] FCIA_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] FCIA_HTRANS_SEQ    = 2'h3;

  // engine states
  typedef enum logic [2:0] {
    FCIA_IDLE   = 3'b001,
    FCIA_ISSUE  = 3'b010,
    FCIA_WAIT   = 3'b100
  } fcia_state_t;

  // command register fields
  typedef struct packed {
    logic        pending;  // indirect_op_pending
    logic        dir_read; // access_direction_sel, 1 = read
    logic        step_up;  // auto increment
    logic        step_dn;  // addr_step_down_en
    logic [3:0]  lanes;    // lane_enables
    logic [15:0] index;    // fabric_reg_index
  } fcia_cmd_t;

  // request toward the fabric register space
  typedef struct packed {
    logic        req;      // one-cycle strobe
    logic        rd;       // 1 = read, 0 = write
    logic [15:0] addr;     // fabric register index
    logic [3:0]  lanes;    // byte lanes for a write
    logic [31:0] wdata;    // write data
  } fcia_fab_req_t;

  // answer from the fabric register space
  typedef struct packed {
    logic        ack;      // one-cycle completion strobe
    logic [31:0] rdata;    // read data, valid with ack
  } fcia_fab_rsp_t;

endpackage

// ===== hdl/fcia_seq.sv
/*
  access sequencer: runs one fabric access per launch and reports completion.
  assumes the fabric answers each request with exactly one ack pulse.
*/
`timescale 1ns/100ps
`default_nettype none

module fcia_seq (
  input  wire logic                   hclk,     // system clock
  input  wire logic                   hresetn,  // async reset, active low
  input  wire logic                   launch,   // start one access
  input  wire logic                   rd,       // direction of the access
  input  wire logic [15:0]            addr,     // fabric register index
  input  wire logic [3:0]             lanes,    // byte lanes
  input  wire logic [31:0]            wdata,    // write value
  output fcia_pkg::fcia_fab_req_t     fab_req,  // request to fabric
  input  wire fcia_pkg::fcia_fab_rsp_t fab_rsp, // answer from fabric
  output logic                        done,     // access finished pulse
  output logic                        busy      // access in flight
);

  fcia_pkg::fcia_state_t state_r;   // current state
  fcia_pkg::fcia_state_t state_nxt; // next state
  fcia_pkg::fcia_fab_req_t req_r;   // registered request

  // state transitions
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      fcia_pkg::FCIA_IDLE:  if (launch) state_nxt = fcia_pkg::FCIA_ISSUE;
      fcia_pkg::FCIA_ISSUE: state_nxt = fcia_pkg::FCIA_WAIT;
      fcia_pkg::FCIA_WAIT:  if (fab_rsp.ack) state_nxt = fcia_pkg::FCIA_IDLE;
      default:              state_nxt = fcia_pkg::FCIA_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= fcia_pkg::FCIA_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // request is captured at launch so later register writes cannot disturb it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_r <= '0;
    end else if (state_r == fcia_pkg::FCIA_IDLE && launch) begin
      req_r <= '{req: 1'b1, rd: rd, addr: addr, lanes: lanes, wdata: wdata};
    end else begin
      req_r.req <= 1'b0;
    end
  end

  assign fab_req = req_r;
  assign done    = (state_r == fcia_pkg::FCIA_WAIT) && fab_rsp.ack;
  assign busy    = (state_r != fcia_pkg::FCIA_IDLE);

endmodule

`default_nettype wire

// ===== tb/fcia_fabric_model.sv
/* fabric register space model: byte-laned writes, reads, slow acks.
   assumes one request in flight, as the engine promises. */
`timescale 1ns/100ps
`default_nettype none
module fcia_fabric_model (
  input  wire logic                    hclk,     // system clock
  input  wire logic                    hresetn,  // async reset, active low
  input  wire logic [3:0]              dly,      // extra cycles before ack
  input  wire fcia_pkg::fcia_fab_req_t req,      // request from engine
  output fcia_pkg::fcia_fab_rsp_t      rsp       // answer to engine
);
  logic [31:0]             mem [0:255];  // low index bits only
  fcia_pkg::fcia_fab_req_t hold_r;       // request being served
  logic [3:0]              cnt_r;        // wait count
  logic                    act_r;        // access in flight
  // rdata toggles outside ack so stale data never looks valid
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_r <= 1'b0;
      rsp <= '0;
    end else begin
      rsp.ack <= 1'b0;
      rsp.rdata <= ~rsp.rdata;
      if (req.req) begin
        hold_r <= req;
        act_r <= 1'b1;
        cnt_r <= dly;
      end else if (act_r && cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end else if (act_r) begin
        act_r <= 1'b0;
        rsp.ack <= 1'b1;
        if (hold_r.rd) rsp.rdata <= mem[hold_r.addr[7:0]];
        for (int b = 0; b < 4; b++)
          if (!hold_r.rd && hold_r.lanes[b])
            mem[hold_r.addr[7:0]][8*b+:8] <= hold_r.wdata[8*b+:8];
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/fcia_top_chk.sv
/* checker for fcia_top: launch, busy and stepping relations.
   assumes hready is looped back from hreadyout. */
`timescale 1ns/100ps
`default_nettype none
module fcia_top_chk (
  input wire logic                    hclk,
  input wire logic                    hresetn,
  input wire logic                    hsel,
  input wire logic [11:0]             haddr,
  input wire logic [1:0]              htrans,
  input wire logic                    hwrite,
  input wire logic [31:0]             hwdata,
  input wire logic                    hready,
  input wire logic [31:0]             hrdata,
  input wire fcia_pkg::fcia_fab_req_t fab_req,
  input wire fcia_pkg::fcia_fab_rsp_t fab_rsp
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic        wc_d, rc_d, wv_d, rv_d;  // data phase per register
  logic        run_r, dir_r, st_r;      // access in flight, mirrored fields
  logic [31:0] frd_r;                   // last fetched fabric data
  wire ap = hsel & hready & htrans[1];
  wire oc = haddr == fcia_pkg::FCIA_CMD_OFS;
  wire ov = haddr == fcia_pkg::FCIA_VALUE_OFS;
  wire busy = fab_req.req | run_r;      // busy shows from the req cycle
  // mirror only what the host may see, refused writes excluded
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wc_d, rc_d, wv_d, rv_d, run_r, dir_r, st_r} <= '0;
      frd_r <= '0;
    end else begin
      {wc_d, rc_d} <= {ap & hwrite & oc, ap & !hwrite & oc};
      {wv_d, rv_d} <= {ap & hwrite & ov, ap & !hwrite & ov};
      run_r <= fab_req.req | (run_r & !fab_rsp.ack);
      if (wc_d & !busy) {dir_r, st_r} <= {hwdata[30], hwdata[29] | hwdata[28]};
      if (fab_rsp.ack & run_r & fab_req.rd) frd_r <= fab_rsp.rdata;
    end
  end
  sequence cmd_go;
    wc_d && hwdata[31] && !busy;
  endsequence
  req_pulse_a: assert property (fab_req.req |=> !fab_req.req)
    else $error("fabric request longer than one cycle");
  cmd_launch_a: assert property (cmd_go |=> fab_req.req
    && fab_req.rd == $past(hwdata[30]) && fab_req.addr == $past(hwdata[15:0]))
    else $error("bad launch");
  lane_pass_a: assert property (cmd_go |=> fab_req.lanes == $past(hwdata[19:16]))
    else $error("lane enables not passed on");
  one_access_a: assert property (fab_req.req |-> !run_r)
    else $error("request while access in flight");
  busy_read_a: assert property (rc_d |-> hrdata[31] == busy)
    else $error("busy bit readback wrong");
  fetch_data_a: assert property (rv_d && dir_r && !busy |-> hrdata == frd_r)
    else $error("value read not fabric data");
  step_wr_a: assert property (wv_d && st_r && !busy |=> fab_req.req
    && !fab_req.rd && fab_req.wdata == $past(hwdata))
    else $error("stepped write not launched");
  step_rd_a: assert property (rv_d && st_r && !busy |=> fab_req.req && fab_req.rd)
    else $error("stepped read not launched");
endmodule
bind fcia_top fcia_top_chk i_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hrdata, .fab_req, .fab_rsp);
`default_nettype wire

// ===== tb/fcia_top_tb.sv
/* bench for fcia_top: ahb-lite master tasks against a fabric model.
   assumes the checker is bound in and hready loops from hreadyout. */
`timescale 1ns/100ps
`default_nettype none
module fcia_top_tb;
  localparam logic [11:0] C = fcia_pkg::FCIA_CMD_OFS;
  localparam logic [11:0] V = fcia_pkg::FCIA_VALUE_OFS;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
  logic [11:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic [31:0] hwdata = '0, hrdata, rv;
  logic [3:0] dly = '0;  // fabric answer delay
  fcia_pkg::fcia_fab_req_t fab_req;
  fcia_pkg::fcia_fab_rsp_t fab_rsp;
  int n_mismatch = 0, total_checks = 0;
  always #2 hclk = ~hclk;
  fcia_top i_fcia_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .fab_req, .fab_rsp);
  fcia_fabric_model i_fcia_fabric_model (.hclk, .hresetn, .dly, .req(fab_req), .rsp(fab_rsp));
  // one single word transfer, entered right after a rising edge
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= fcia_pkg::FCIA_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, '0);
    chk(nm, e, rv);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  // poll busy with a bound so a stuck engine is reported, not hung on
  task automatic idle();
    int k = 0;
    do begin
      bus(1'b0, C, '0);
      k++;
    end while (rv[31] !== 1'b0 && k < 40);
    chk("idle", 32'h0, {31'h0, rv[31]});
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(C, 32'h0, "cmd_rst");
    rd(V, 32'h0, "val_rst");
    bus(1'b1, 12'h1b4, 32'hffff_ffff);
    rd(12'h1b4, 32'h0, "unmapped");
    rd(C, 32'h0, "cmd_kept");
    for (int b = 0; b < 4; b++) begin
      i_fcia_fabric_model.mem[b] = 32'h0;
      bus(1'b1, V, 32'hffff_ffff);
      bus(1'b1, C, {12'h800, 4'(1 << b), 16'(b)});
      idle();
      chk("lane", 32'hff << (8 * b), i_fcia_fabric_model.mem[b]);
    end
    dly <= 4'h6;
    i_fcia_fabric_model.mem[8'h20] = 32'h5a5a_1234;
    bus(1'b1, C, 32'hc000_0020);
    rd(C, 32'hc000_0020, "busy_set");
    bus(1'b1, C, 32'h0000_1234);
    idle();
    rd(C, 32'h4000_0020, "no_overwrite");
    rd(V, 32'h5a5a_1234, "fetched");
    bus(1'b1, C, 32'h0000_0020);
    rd(V, 32'hffff_ffff, "host_val");
    dly <= 4'h0;
    bus(1'b1, C, 32'h300f_ffff);
    bus(1'b1, V, 32'hcafe_0001);
    idle();
    rd(C, 32'h300f_0000, "inc_wrap");
    chk("inc_wr", 32'hcafe_0001, i_fcia_fabric_model.mem[8'hff]);
    bus(1'b1, C, 32'h100f_0000);
    bus(1'b1, V, 32'h0bad_f00d);
    idle();
    rd(C, 32'h100f_ffff, "dec_wrap");
    chk("dec_wr", 32'h0bad_f00d, i_fcia_fabric_model.mem[0]);
    i_fcia_fabric_model.mem[8'h10] = 32'h1357_9bdf;
    bus(1'b1, C, 32'h500f_0011);
    rd(V, 32'h5a5a_1234, "old_fetch");
    idle();
    rd(C, 32'h500f_0010, "dec_pre");
    bus(1'b1, C, 32'h400f_0010);
    rd(V, 32'h1357_9bdf, "dec_data");
    rd(C, 32'h400f_0010, "no_extra");
    bus(1'b1, C, 32'h600f_000f);
    rd(V, 32'h1357_9bdf, "inc_old");
    idle();
    rd(C, 32'h600f_0010, "inc_pre");
    close_out();
  end
  initial begin
    #20000;
    n_mismatch++;
    close_out();
  end
endmodule
`default_nettype wire
